// File: hw/isfu_unit.v
// subtract-from datapath with an axi4-lite register window
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`include "isfu_map.vh"
module isfu_unit (
  input  wire        mclk,
  input  wire        rstn,
  input  wire        clk_en,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  output reg  [1:0]  s_axi_bresp,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  input  wire [7:0]  s_axi_araddr,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         busy_q
);
  reg  [63:0] src_a_q;
  reg  [63:0] src_b_q;
  reg  [31:0] ctrl_q;
  reg  [2:0]  xer_q;
  reg  [63:0] res_q;
  reg  [3:0]  cr0_q;
  reg         aw_hold_q;
  reg  [7:0]  aw_addr_q;
  reg         w_hold_q;
  reg  [31:0] w_data_q;
  reg  [3:0]  w_strb_q;
  reg         go_q;

  // byte-lane merge, used for every writable word
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  strb;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1)
        if (strb[i])
          merge[i*8 +: 8] = nw[i*8 +: 8];
    end
  endfunction

  // signed sign test of a result against zero, four-bit field
  function [3:0] cmp_zero;
    input [63:0] r;
    input        so;
    begin
      if (r[63])
        cmp_zero = {1'b1, 1'b0, 1'b0, so};
      else if (r == 64'h0)
        cmp_zero = {1'b0, 1'b0, 1'b1, so};
      else
        cmp_zero = {1'b0, 1'b1, 1'b0, so};
    end
  endfunction

  // address decode shared by both channels; result and cr0 words are read-only
  function addr_hit;
    input [7:0] addr;
    input       wr;
    begin
      if (addr[1:0] != 2'b00)
        addr_hit = 1'b0;
      else if (wr)
        addr_hit = (addr <= `ISFU_OFS_XER);
      else
        addr_hit = (addr <= `ISFU_OFS_CR0);
    end
  endfunction

  wire [2:0]  op     = ctrl_q[`ISFU_CTL_OP_MSB:`ISFU_CTL_OP_LSB];
  wire        rec    = ctrl_q[`ISFU_CTL_RECORD];
  wire        oven   = ctrl_q[`ISFU_CTL_OVEN];
  wire        mode64 = ctrl_q[`ISFU_CTL_MODE64];
  wire [15:0] imm    = ctrl_q[`ISFU_CTL_IMM_MSB:`ISFU_CTL_IMM_LSB];
  wire        ca_in  = xer_q[`ISFU_XER_CA];

  reg  [63:0] opnd_b;
  reg         cin;
  reg         ca_upd;
  reg         reg_form;
  wire [63:0] sum;
  wire        cout;
  wire        ovf;

  // operand and carry select per variant
  always @*
  begin
    opnd_b   = src_b_q;
    cin      = 1'b1;
    ca_upd   = 1'b0;
    reg_form = 1'b1;
    case (op)
      `ISFU_OP_PLAIN:
      begin
        opnd_b = src_b_q;
        cin    = 1'b1;
        ca_upd = 1'b0; // plain form keeps the carry bit
      end
      `ISFU_OP_CARRY:
      begin
        opnd_b = src_b_q;
        cin    = 1'b1;
        ca_upd = 1'b1;
      end
      `ISFU_OP_EXT:
      begin
        opnd_b = src_b_q;
        cin    = ca_in;
        ca_upd = 1'b1;
      end
      `ISFU_OP_IMM:
      begin
        opnd_b   = {{48{imm[15]}}, imm};
        cin      = 1'b1;
        ca_upd   = 1'b1;
        reg_form = 1'b0; // no record or overflow forms
      end
      `ISFU_OP_MINUS1:
      begin
        opnd_b = 64'hFFFF_FFFF_FFFF_FFFF;
        cin    = ca_in;
        ca_upd = 1'b1;
      end
      `ISFU_OP_ZERO:
      begin
        opnd_b = 64'h0; // no second operand
        cin    = ca_in;
        ca_upd = 1'b1;
      end
      default:
      begin
        // unused codes behave as the plain form, carry untouched
        opnd_b = src_b_q;
        cin    = 1'b1;
        ca_upd = 1'b0;
      end
    endcase
  end

  isfu_adder u_add (
    .not_a  (~src_a_q),
    .opnd_b (opnd_b),
    .cin    (cin),
    .mode64 (mode64),
    .sum    (sum),
    .cout   (cout),
    .ovf    (ovf)
  );

  wire so_next = xer_q[`ISFU_XER_SO] | (reg_form & oven & ovf); // sticky

  // write response decided from the held address, only valid once both halves are in
  wire        wr_map  = addr_hit(aw_addr_q, 1'b1);

  // write channel: address and data taken in either order, then answered
  // readies hold while clk_en is low, so no request may be changed then
  always @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'b00;
      aw_hold_q     <= 1'b0;
      aw_addr_q     <= 8'h00;
      w_hold_q      <= 1'b0;
      w_data_q      <= 32'h0;
      w_strb_q      <= 4'h0;
    end
    else if (clk_en)
    begin
      s_axi_awready <= ~aw_hold_q & ~s_axi_awready & ~s_axi_bvalid;
      s_axi_wready  <= ~w_hold_q & ~s_axi_wready & ~s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_hold_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_hold_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (aw_hold_q && w_hold_q && !s_axi_bvalid)
      begin
        aw_hold_q    <= 1'b0;
        w_hold_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_map ? 2'b00 : 2'b10; // slverr on unmapped
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  wire wr_do = aw_hold_q & w_hold_q & ~s_axi_bvalid;
  // software view of the exception bits, merged by byte lane
  wire [31:0] xer_wr = merge({29'h0, xer_q}, w_data_q, w_strb_q);

  // operand and control registers; a ctrl write launches an operation
  always @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      src_a_q <= 64'h0;
      src_b_q <= 64'h0;
      ctrl_q  <= `ISFU_CTRL_RST;
      go_q    <= 1'b0;
      busy_q  <= 1'b0;
    end
    else if (clk_en)
    begin
      go_q   <= 1'b0;
      busy_q <= 1'b0;
      if (wr_do)
      begin
        case (aw_addr_q)
          `ISFU_OFS_SRC_A_LO: src_a_q[31:0]  <= merge(src_a_q[31:0], w_data_q, w_strb_q);
          `ISFU_OFS_SRC_A_HI: src_a_q[63:32] <= merge(src_a_q[63:32], w_data_q, w_strb_q);
          `ISFU_OFS_SRC_B_LO: src_b_q[31:0]  <= merge(src_b_q[31:0], w_data_q, w_strb_q);
          `ISFU_OFS_SRC_B_HI: src_b_q[63:32] <= merge(src_b_q[63:32], w_data_q, w_strb_q);
          `ISFU_OFS_CTRL:
          begin
            ctrl_q <= merge(ctrl_q, w_data_q, w_strb_q);
            go_q   <= 1'b1;
            busy_q <= 1'b1;
          end
          default: ;
        endcase
      end
    end
  end

  // result, exception bits and condition field
  always @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      res_q <= 64'h0;
      xer_q <= `ISFU_XER_RST;
      cr0_q <= 4'h0;
    end
    else if (clk_en)
    begin
      if (go_q)
      begin
        res_q <= sum;
        if (ca_upd)
          xer_q[`ISFU_XER_CA] <= cout; // plain form keeps carry
        if (reg_form && oven)
        begin
          xer_q[`ISFU_XER_OV] <= ovf;
          xer_q[`ISFU_XER_SO] <= so_next; // never cleared here
        end
        if (reg_form && rec)
          cr0_q <= cmp_zero(sum, so_next); // truncated result used
      end
      else if (wr_do && aw_addr_q == `ISFU_OFS_XER)
        xer_q <= xer_wr[2:0]; // software clear
    end
  end

  // read channel: one-cycle answer after address taken
  always @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= 2'b00;
    end
    else if (clk_en)
    begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= addr_hit(s_axi_araddr, 1'b0) ? 2'b00 : 2'b10;
        case (s_axi_araddr)
          `ISFU_OFS_SRC_A_LO: s_axi_rdata <= src_a_q[31:0];
          `ISFU_OFS_SRC_A_HI: s_axi_rdata <= src_a_q[63:32];
          `ISFU_OFS_SRC_B_LO: s_axi_rdata <= src_b_q[31:0];
          `ISFU_OFS_SRC_B_HI: s_axi_rdata <= src_b_q[63:32];
          `ISFU_OFS_CTRL:     s_axi_rdata <= ctrl_q;
          `ISFU_OFS_XER:      s_axi_rdata <= {29'h0, xer_q};
          `ISFU_OFS_RES_LO:   s_axi_rdata <= res_q[31:0];
          `ISFU_OFS_RES_HI:   s_axi_rdata <= res_q[63:32];
          `ISFU_OFS_CR0:      s_axi_rdata <= {28'h0, cr0_q};
          default:
          begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= 2'b10;
          end
        endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end
endmodule // isfu_unit

// File: hw/isfu_map.vh
// constants for the subtract-from datapath and its register window
// Notes on behaviour
// - plain form: inverse a plus b plus one
// - record bit updates condition field zero
// - overflow enable updates overflow and summary
// - carrying form always updates carry bit
// - carry, overflow from 64 or 32 bits
// - flags reflect truncated result on overflow
// - extended form adds incoming carry bit
// - immediate form: sign extended, carry only
// - minus-one form adds carry plus all ones
// - zero form adds carry, no b operand
`ifndef ISFU_MAP_VH
`define ISFU_MAP_VH
// byte offsets of the register window
`define ISFU_OFS_SRC_A_LO   8'h00
`define ISFU_OFS_SRC_A_HI   8'h04
`define ISFU_OFS_SRC_B_LO   8'h08
`define ISFU_OFS_SRC_B_HI   8'h0C
`define ISFU_OFS_CTRL       8'h10
`define ISFU_OFS_XER        8'h14
`define ISFU_OFS_RES_LO     8'h18
`define ISFU_OFS_RES_HI     8'h1C
`define ISFU_OFS_CR0        8'h20
// control register fields
`define ISFU_CTL_OP_LSB     0
`define ISFU_CTL_OP_MSB     2
`define ISFU_CTL_RECORD     4
`define ISFU_CTL_OVEN       5
`define ISFU_CTL_MODE64     6
`define ISFU_CTL_IMM_LSB    16
`define ISFU_CTL_IMM_MSB    31
// exception register fields
`define ISFU_XER_CA         0
`define ISFU_XER_OV         1
`define ISFU_XER_SO         2
// operation selects
`define ISFU_OP_PLAIN       3'h0
`define ISFU_OP_CARRY       3'h1
`define ISFU_OP_EXT         3'h2
`define ISFU_OP_IMM         3'h3
`define ISFU_OP_MINUS1      3'h4
`define ISFU_OP_ZERO        3'h5
// reset values
`define ISFU_CTRL_RST       32'h0000_0040
`define ISFU_XER_RST        3'h0
`endif

// File: hw/isfu_adder.v
// combinational subtract-from adder with 64 and 32 bit status
`timescale 1ns/10ps
module isfu_adder (
  input  wire [63:0] not_a,
  input  wire [63:0] opnd_b,
  input  wire        cin,
  input  wire        mode64,
  output wire [63:0] sum,
  output wire        cout,
  output wire        ovf
);
  wire [64:0] full;
  wire [32:0] low;

  // full sum and low-word sum for mode select
  assign full = {1'b0, not_a} + {1'b0, opnd_b} + {64'h0, cin};
  assign low  = {1'b0, not_a[31:0]} + {1'b0, opnd_b[31:0]} + {32'h0, cin};
  assign sum  = full[63:0];
  // status taken from result width in use
  assign cout = mode64 ? full[64] : low[32];
  assign ovf  = mode64 ? ((not_a[63] == opnd_b[63]) && (full[63] != not_a[63]))
                       : ((not_a[31] == opnd_b[31]) && (low[31] != not_a[31]));
endmodule // isfu_adder

// File: testbench/isfu_unit_chk.sv
// protocol and status checker for the subtract-from unit
`timescale 1ns/10ps
module isfu_unit_chk (
  input logic        mclk,
  input logic        rstn,
  input logic        clk_en,
  input logic        s_axi_awready,
  input logic        s_axi_wready,
  input logic        s_axi_bvalid,
  input logic        s_axi_bready,
  input logic [1:0]  s_axi_bresp,
  input logic        s_axi_arvalid,
  input logic        s_axi_arready,
  input logic        s_axi_rvalid,
  input logic        s_axi_rready,
  input logic [31:0] s_axi_rdata,
  input logic [1:0]  s_axi_rresp,
  input logic        busy_q
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  // read address accepted, then a stalled read answer
  sequence ar_taken;
    s_axi_arvalid && s_axi_arready && clk_en;
  endsequence
  sequence r_stall;
    s_axi_rvalid && !s_axi_rready;
  endsequence
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  r_hold_a: assert property (r_stall |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  r_latency_a: assert property (ar_taken |=> s_axi_rvalid)
    else $error("read answer late");
  busy_pulse_a: assert property (busy_q && clk_en |=> !busy_q)
    else $error("busy longer than one cycle");
  busy_cause_a: assert property (busy_q |-> s_axi_bvalid || $past(s_axi_bvalid))
    else $error("busy without a write");
  // a pending answer blocks new requests on its channel
  w_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  err_data_a: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
    else $error("error read returns data");
  // a low clock enable freezes both address readies, both answer valids and busy_q
  freeze_a: assert property (!clk_en |=> $stable(s_axi_awready) && $stable(s_axi_arready)
    && $stable(s_axi_bvalid) && $stable(s_axi_rvalid) && $stable(busy_q))
    else $error("state moved while clock enable low");
endmodule // isfu_unit_chk

bind isfu_unit isfu_unit_chk u_chk (.mclk, .rstn, .clk_en, .s_axi_awready, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .busy_q);

// File: testbench/isfu_axi_master.sv
// bus master standing in for the decoder and register file side
`timescale 1ns/10ps
module isfu_axi_master (
  input  logic        mclk,
  output logic        s_axi_awvalid,
  input  logic        s_axi_awready,
  output logic [7:0]  s_axi_awaddr,
  output logic        s_axi_wvalid,
  input  logic        s_axi_wready,
  output logic [31:0] s_axi_wdata,
  input  logic        s_axi_bvalid,
  output logic        s_axi_bready,
  input  logic [1:0]  s_axi_bresp,
  output logic        s_axi_arvalid,
  input  logic        s_axi_arready,
  output logic [7:0]  s_axi_araddr,
  input  logic        s_axi_rvalid,
  output logic        s_axi_rready,
  input  logic [31:0] s_axi_rdata,
  input  logic [1:0]  s_axi_rresp
);
  // idle bus from time zero, nothing offered during reset
  initial
  begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
  end
  // each channel drops valid only at the edge its own ready is seen
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do
    begin
      @(posedge mclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge mclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do
    begin
      @(posedge mclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
endmodule // isfu_axi_master

// File: testbench/isfu_unit_tb.sv
// self-checking bench for the subtract-from unit
`timescale 1ns/10ps
`include "isfu_map.vh"
module isfu_unit_tb;
  logic        mclk, rstn, busy_q, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, clk_en;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [2:0]  fixed_point_exception_reg; // model of {summary, overflow, carry}
  logic [3:0]  cr0;
  int          failures, tests_run;
  isfu_unit u_isfu_unit (.mclk, .rstn, .clk_en, .s_axi_awvalid, .s_axi_awready,
    .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb(4'hF),
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
    .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .busy_q);
  isfu_axi_master bus (.*);
  task automatic chk(input string nm, input logic [63:0] s, e);
    tests_run++;
    if (s !== e)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic summarize();
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // reference sum worked out here, then the result, exception and condition words read back
  task automatic run(input logic [63:0] a, b, input logic [31:0] c);
    logic [63:0] y, s;
    logic [64:0] f;
    logic [32:0] l;
    logic [2:0]  o;
    logic        ci, ov;
    o = c[2:0];
    y = (o < 3) ? b : (o == 3) ? {{48{c[31]}}, c[31:16]} : (o == 4) ? '1 : '0;
    ci = (o < 2 || o == 3) ? 1'b1 : fixed_point_exception_reg[0];
    f = {1'b0, ~a} + {1'b0, y} + ci;
    l = {1'b0, ~a[31:0]} + {1'b0, y[31:0]} + ci;
    s = f[63:0];
    ov = c[6] ? (~a[63] == y[63] && s[63] != y[63]) : (~a[31] == y[31] && s[31] != y[31]);
    if (o != 0) fixed_point_exception_reg[0] = c[6] ? f[64] : l[32];
    if (c[5] && o != 3) fixed_point_exception_reg[2:1] = {fixed_point_exception_reg[2] | ov, ov};
    if (c[4] && o != 3) cr0 = {s[63], !s[63] && s != 0, s == 0, fixed_point_exception_reg[2]};
    bus.wr(`ISFU_OFS_SRC_A_LO, a[31:0], rsp);
    bus.wr(`ISFU_OFS_SRC_A_HI, a[63:32], rsp);
    bus.wr(`ISFU_OFS_SRC_B_LO, b[31:0], rsp);
    bus.wr(`ISFU_OFS_SRC_B_HI, b[63:32], rsp);
    bus.wr(`ISFU_OFS_CTRL, c, rsp);
    chk("ctrl response", rsp, 2'h0);
    @(posedge mclk);
    bus.rd(`ISFU_OFS_RES_LO, rd, rsp);
    chk("result low", rd, s[31:0]);
    bus.rd(`ISFU_OFS_RES_HI, rd, rsp);
    chk("result high", rd, s[63:32]);
    bus.rd(`ISFU_OFS_XER, rd, rsp);
    chk("exception reg", rd[2:0], fixed_point_exception_reg);
    bus.rd(`ISFU_OFS_CR0, rd, rsp);
    chk("condition field", rd[3:0], cr0);
  endtask
  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  // a hang ends the run with a counted failure
  initial
  begin
    #200000;
    failures++;
    summarize();
  end
  initial
  begin
    {failures, tests_run, fixed_point_exception_reg, cr0, rstn} = '0;
    clk_en = 1'b1;
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    bus.rd(`ISFU_OFS_CTRL, rd, rsp);
    chk("ctrl reset", rd, `ISFU_CTRL_RST);
    bus.rd(8'h24, rd, rsp);
    chk("unmapped read", rsp, 2'h2);
    bus.wr(`ISFU_OFS_RES_LO, 32'h1, rsp);
    chk("result write", rsp, 2'h2);
    run(64'h5, 64'h3, 32'h70);
    run(64'h1, 64'h1, 32'h71);
    run(64'h0, 64'h5, 32'h72);
    run(64'h2, 64'h0, 32'hFFFF_0073);
    run(64'h0, 64'h0, 32'h74);
    run('1, 64'h0, 32'h75);
    run(64'h1, 64'h8000_0000_0000_0000, 32'h70);
    run(64'h1, 64'h1_0000_0000, 32'h31);
    run(64'h3, 64'h3, 32'h40);
    // freeze with the bus idle: a frozen ready would swallow a transfer
    clk_en <= 1'b0;
    repeat (6) @(posedge mclk);
    clk_en <= 1'b1;
    bus.wr(`ISFU_OFS_XER, 32'h0, rsp);
    fixed_point_exception_reg = 3'h0;
    bus.rd(`ISFU_OFS_XER, rd, rsp);
    chk("exception clear", rd[2:0], fixed_point_exception_reg);
    summarize();
  end
endmodule // isfu_unit_tb
